/* logic/sequencer_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the
//          clock startup sequencer.
// Assumes: Register offsets are byte addresses on a plain register port.
// Notes:   Definitions only.
`ifndef SEQUENCER_CONSTS_SVH
`define SEQUENCER_CONSTS_SVH

// ==========================================================
// Sizes
`define NUM_OUT 7
`define SEQ_W 3
`define CNT_W 6
`define ADDR_W 4

// ==========================================================
// Counts
`define LOCK_STABLE_CYCLES 6'h20
`define SEQ_GAP_FB_CYCLES 6'h20

// ==========================================================
// Register offsets
`define REG_CTRL 4'h0
`define REG_ORDER 4'h4
`define REG_STATUS 4'h8
`define REG_CONFIG 4'hc

// ==========================================================
// Control fields and reset values
`define CTRL_SAFE_BIT 0
`define CTRL_SEQ_BIT 1
`define CTRL_REF_BIT 2
`define CTRL_SAFE_RESET 1'h1
`define CTRL_SEQ_RESET 1'h0
`define ORDER_RESET 21'h0

// ==========================================================
// Status fields
`define STAT_GATE_LSB 0
`define STAT_STATE_LSB 7
`define STAT_POS_LSB 9
`define STAT_LOCK_BIT 12
`define STAT_REF_BIT 13
`define STAT_LEGAL_BIT 14

`endif

/* logic/sequencer_pkg.sv */
// Purpose: Types of the clock startup sequencer.
// Assumes: sequencer_consts.svh supplies the sizes.
// Notes:   The whole state of the sequencer is one packed struct.
`include "sequencer_consts.svh"

package sequencer_pkg;

    // ==========================================================
    // Startup states
    typedef enum logic [1:0] {
        st_wait_lock = 2'b00,
        st_sequence = 2'b01,
        st_running = 2'b10
    } seq_state_t;

    // ==========================================================
    // Complete register state
    typedef struct packed {
        logic lock_s1;
        logic lock_s2;
        logic fb_s1;
        logic fb_s2;
        logic fb_s3;
        logic safe_en;
        logic seq_en;
        logic ref_sel;
        logic [`NUM_OUT*`SEQ_W-1:0] order;
        seq_state_t st;
        logic [`CNT_W-1:0] cnt;
        logic [`SEQ_W-1:0] pos;
        logic [`NUM_OUT-1:0] gate;
        logic ref_act;
        logic legal;
        logic [31:0] rdata;
    } seq_regs_t;

endpackage

/* logic/safe_clock_startup_sequencer.sv */
// Purpose: Holds output clock gates shut until lock is stable, then opens
//          them at once or in a programmed order; picks the reference.
// Assumes: clk is the input reference clock domain (40 MHz); lock_in and
//          fb_clk_in come from the clock manager, asynchronous to clk.
// Notes:   Feedback clock is sampled, so it must run well below clk/2.
// Function
// RULE1: With safe startup, gates stay shut until lock held for 32 cycles.
// RULE2: With sequencing, outputs open one by one in programmed order; the code opens all outputs that share an order slot together.
// RULE3: Consecutive sequence steps are 32 feedback clock cycles apart.
// RULE4: Two references; a select bit chooses the active one.
// RULE5: With spread spectrum built in, only the primary reference is used.
// RULE6: Reference 10-1066 MHz, or 25-150 MHz with spread spectrum; the code does not check the reference frequency.
// RULE7: Dynamic reconfiguration needs integer multiplier and dividers.
// RULE8: Spread spectrum excludes phase shifting and minimum power.
// RULE9: Minimum jitter and maximum input filtering are mutually exclusive.
// RULE10: Lock loss shuts all gates, clears counts, restarts startup.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sequencer_consts.svh"

module safe_clock_startup_sequencer #(
    parameter bit SS_EN = 1'b0,
    parameter bit DPS_EN = 1'b0,
    parameter bit MINPWR_EN = 1'b0,
    parameter bit DYNRECFG_EN = 1'b0,
    parameter bit MINJIT_EN = 1'b0,
    parameter bit MAXFILT_EN = 1'b0,
    parameter logic [2:0] MULT_FRAC = 3'h0,
    parameter logic [2:0] IN_DIV_FRAC = 3'h0,
    parameter logic [2:0] OUT_DIV_FRAC = 3'h0,
    parameter logic [`CNT_W-1:0] LOCK_CYCLES = `LOCK_STABLE_CYCLES,
    parameter logic [`CNT_W-1:0] GAP_CYCLES = `SEQ_GAP_FB_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic lock_in,
    input wire logic fb_clk_in,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic [`NUM_OUT-1:0] gate_en,
    output logic ref_sel_out,
    output logic config_legal
);

    // ==========================================================
    // State and decoded helpers
    sequencer_pkg::seq_regs_t r_q;
    sequencer_pkg::seq_regs_t r_d;
    logic fb_edge;
    logic cfg_legal;
    logic [5:0] cfg_bits;
    logic [`NUM_OUT-1:0] now_mask;
    logic [`NUM_OUT-1:0] later_mask;

    // Rising feedback edge, seen only past the synchroniser
    assign fb_edge = r_q.fb_s2 & ~r_q.fb_s3;

    // Build-time feature legality
    assign cfg_legal = !(SS_EN && (DPS_EN || MINPWR_EN)) // RULE8
        && !(MINJIT_EN && MAXFILT_EN) // RULE9
        && !(DYNRECFG_EN && ((MULT_FRAC | IN_DIV_FRAC | OUT_DIV_FRAC)
            != 3'h0)); // RULE7
    assign cfg_bits = {MAXFILT_EN, MINJIT_EN, DYNRECFG_EN,
        MINPWR_EN, DPS_EN, SS_EN};

    // Outputs due at the current sequence position, and those still later
    always_comb begin
        for (int i = 0; i < `NUM_OUT; i++) begin
            now_mask[i] = r_q.order[i*`SEQ_W +: `SEQ_W] == r_q.pos; // RULE2
            later_mask[i] = r_q.order[i*`SEQ_W +: `SEQ_W] > r_q.pos;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        r_d = r_q;
        // Two-flop synchronisers
        r_d.lock_s1 = lock_in;
        r_d.lock_s2 = r_q.lock_s1;
        r_d.fb_s1 = fb_clk_in;
        r_d.fb_s2 = r_q.fb_s1;
        r_d.fb_s3 = r_q.fb_s2;
        // Register writes
        if (wr) begin
            unique case (addr)
                `REG_CTRL: begin
                    r_d.safe_en = wdata[`CTRL_SAFE_BIT];
                    r_d.seq_en = wdata[`CTRL_SEQ_BIT];
                    r_d.ref_sel = wdata[`CTRL_REF_BIT]; // RULE4
                end
                `REG_ORDER: begin
                    r_d.order = wdata[`NUM_OUT*`SEQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Register reads, data valid for one cycle only
        r_d.rdata = 32'h0;
        if (rd) begin
            unique case (addr)
                `REG_CTRL: begin
                    r_d.rdata[`CTRL_SAFE_BIT] = r_q.safe_en;
                    r_d.rdata[`CTRL_SEQ_BIT] = r_q.seq_en;
                    r_d.rdata[`CTRL_REF_BIT] = r_q.ref_sel;
                end
                `REG_ORDER: begin
                    r_d.rdata[`NUM_OUT*`SEQ_W-1:0] = r_q.order;
                end
                `REG_STATUS: begin
                    r_d.rdata[`STAT_GATE_LSB +: `NUM_OUT] = r_q.gate;
                    r_d.rdata[`STAT_STATE_LSB +: 2] = r_q.st;
                    r_d.rdata[`STAT_POS_LSB +: `SEQ_W] = r_q.pos;
                    r_d.rdata[`STAT_LOCK_BIT] = r_q.lock_s2;
                    r_d.rdata[`STAT_REF_BIT] = r_q.ref_act;
                    r_d.rdata[`STAT_LEGAL_BIT] = r_q.legal;
                end
                `REG_CONFIG: begin
                    r_d.rdata[5:0] = cfg_bits;
                end
                default: begin
                end
            endcase
        end
        // Reference choice, secondary blocked under spread spectrum
        r_d.ref_act = SS_EN ? 1'b0 : r_q.ref_sel; // RULE4 RULE5
        r_d.legal = cfg_legal;
        // Startup sequencing
        if (!r_q.lock_s2) begin
            r_d.st = sequencer_pkg::st_wait_lock; // RULE10
            r_d.cnt = '0;
            r_d.pos = '0;
            r_d.gate = '0;
        end else begin
            unique case (r_q.st)
                sequencer_pkg::st_wait_lock: begin
                    if (!r_q.safe_en
                        || r_q.cnt == LOCK_CYCLES - 6'h01) begin // RULE1
                        r_d.cnt = '0;
                        r_d.pos = '0;
                        if (r_q.seq_en) begin
                            r_d.st = sequencer_pkg::st_sequence;
                        end else begin
                            r_d.st = sequencer_pkg::st_running;
                            r_d.gate = '1;
                        end
                    end else begin
                        r_d.cnt = r_q.cnt + 6'h01;
                    end
                end
                sequencer_pkg::st_sequence: begin
                    r_d.gate = r_q.gate | now_mask; // RULE2
                    if (later_mask == '0) begin
                        r_d.st = sequencer_pkg::st_running;
                    end else if (fb_edge) begin
                        if (r_q.cnt == GAP_CYCLES - 6'h01) begin // RULE3
                            r_d.cnt = '0;
                            r_d.pos = r_q.pos + 3'h1;
                        end else begin
                            r_d.cnt = r_q.cnt + 6'h01;
                        end
                    end
                end
                sequencer_pkg::st_running: begin
                    r_d.gate = '1;
                end
                default: begin
                    r_d.st = sequencer_pkg::st_wait_lock;
                end
            endcase
        end
    end

    // ==========================================================
    // State register, synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r_q <= '0;
            r_q.safe_en <= `CTRL_SAFE_RESET;
            r_q.seq_en <= `CTRL_SEQ_RESET;
            r_q.order <= `ORDER_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = r_q.rdata;
    assign gate_en = r_q.gate;
    assign ref_sel_out = r_q.ref_act;
    assign config_legal = r_q.legal;

    // ==========================================================
    // Checks: helper counters
    logic [7:0] lock_run_q;
    logic [7:0] fb_since_q;
    always_ff @(posedge clk) begin
        if (!rstn || !r_q.lock_s2) begin
            lock_run_q <= 8'h0;
        end else if (lock_run_q != 8'hff) begin
            lock_run_q <= lock_run_q + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn || r_q.st != sequencer_pkg::st_sequence
            || r_q.pos != r_d.pos) begin
            fb_since_q <= 8'h0;
        end else if (fb_edge && fb_since_q != 8'hff) begin
            fb_since_q <= fb_since_q + 8'h01;
        end
    end

    sequence s_ctrl_write;
        wr && addr == `REG_CTRL;
    endsequence
    sequence s_ref_follows;
        ##2 ref_sel_out == $past(wdata[`CTRL_REF_BIT], 2);
    endsequence

    property p_gate_after_stable;
        @(posedge clk) disable iff (!rstn)
        ($rose(|gate_en) && $past(r_q.safe_en)) |-> lock_run_q >= 8'h20;
    endproperty
    a_gate_after_stable: assert property (p_gate_after_stable) // RULE1
        else $error("Gate opened before lock was stable");

    property p_shut_while_unstable;
        @(posedge clk) disable iff (!rstn)
        (r_q.safe_en && $past(r_q.safe_en) && lock_run_q < 8'h20)
            |-> gate_en == '0;
    endproperty
    a_shut_while_unstable: assert property (p_shut_while_unstable) // RULE1
        else $error("Gate open during lock settling");

    property p_no_early_output;
        @(posedge clk) disable iff (!rstn)
        r_q.st == sequencer_pkg::st_sequence |-> (gate_en & later_mask) == '0;
    endproperty
    a_no_early_output: assert property (p_no_early_output) // RULE2
        else $error("Output opened ahead of its sequence slot");

    property p_step_gap;
        @(posedge clk) disable iff (!rstn)
        (r_q.pos != r_d.pos && r_d.pos != '0) |-> fb_since_q == 8'h1f;
    endproperty
    a_step_gap: assert property (p_step_gap) // RULE3
        else $error("Sequence step not 32 feedback cycles apart");

    property p_ref_select;
        @(posedge clk) disable iff (!rstn)
        s_ctrl_write ##0 !SS_EN |-> s_ref_follows;
    endproperty
    a_ref_select: assert property (p_ref_select) // RULE4
        else $error("Reference select did not follow control write");

    property p_primary_only;
        @(posedge clk) disable iff (!rstn)
        SS_EN |-> ##1 !ref_sel_out;
    endproperty
    a_primary_only: assert property (p_primary_only) // RULE5
        else $error("Secondary reference active with spread spectrum");

    property p_fraction_illegal;
        @(posedge clk) disable iff (!rstn)
        (DYNRECFG_EN && (MULT_FRAC | IN_DIV_FRAC | OUT_DIV_FRAC) != 3'h0)
            |-> !config_legal;
    endproperty
    a_fraction_illegal: assert property (p_fraction_illegal) // RULE7
        else $error("Fractional divide accepted with reconfiguration");

    property p_lock_loss;
        @(posedge clk) disable iff (!rstn)
        !r_q.lock_s2 |=> gate_en == '0 && r_q.pos == '0
            && r_q.st == sequencer_pkg::st_wait_lock;
    endproperty
    a_lock_loss: assert property (p_lock_loss) // RULE10
        else $error("Startup not restarted after lock loss");

    property p_running_open;
        @(posedge clk) disable iff (!rstn)
        (r_q.st == sequencer_pkg::st_running && r_q.lock_s2)
            |=> gate_en == '1;
    endproperty
    a_running_open: assert property (p_running_open) // RULE2
        else $error("Output still shut after sequence end");

    property p_illegal_set;
        @(posedge clk) disable iff (!rstn)
        ((SS_EN && (DPS_EN || MINPWR_EN)) || (MINJIT_EN && MAXFILT_EN))
            |-> !config_legal;
    endproperty
    a_illegal_set: assert property (p_illegal_set) // RULE8 RULE9
        else $error("Excluded feature pair reported as legal");

    property p_rdata_one_cycle;
        @(posedge clk) disable iff (!rstn)
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle)
        else $error("Read data present without a read");

endmodule

/* dv/clock_manager_model.sv */
// Purpose: Behavioural clock manager: feedback clock and lock flag.
// Assumes: run high means the manager is powered and tracking.
// Notes:   Feedback clock stands low while stopped; lock drops at once.
`timescale 1ns/1ps

module clock_manager_model #(
    parameter int HALF = 100,
    parameter int LOCK_EDGES = 4
) (
    input wire logic run,
    output logic lock,
    output logic fb_clk
);
    int n;

    // ==========================================================
    // Feedback clock, 5 MHz, well below half the sampling clock
    initial begin
        fb_clk = 1'b0;
        lock = 1'b0;
        n = 0;
    end
    always begin
        #HALF;
        fb_clk = run ? ~fb_clk : 1'b0;
    end

    // Lock rises after a few feedback edges, falls when stopped
    always @(posedge fb_clk or negedge run) begin
        if (!run) begin
            n = 0;
            lock = 1'b0;
        end else if (n < LOCK_EDGES) begin
            n = n + 1;
        end else begin
            lock = 1'b1;
        end
    end
endmodule

/* dv/safe_clock_startup_sequencer_tb.sv */
// Purpose: Self-checking bench of the clock startup sequencer.
// Assumes: Default counts of 32; feedback clock from the partner model.
// Notes:   Register rows first, then reference select, startup, sequencing with lock loss, and reset.
`timescale 1ns/1ps
`include "sequencer_consts.svh"

module safe_clock_startup_sequencer_tb;
    typedef struct packed {
        logic w;
        logic [`ADDR_W-1:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic [`ADDR_W-1:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [`NUM_OUT-1:0] gate_en;
    logic lock_in, fb_clk_in, ref_sel_out, config_legal;
    logic ss_ref, ss_legal, bad_legal, frac_legal, jit_legal;
    int mismatches = 0;
    int cmp_count = 0;
    row_t rows [7] = '{
        '{1'b0, `REG_CTRL, 32'h0, 32'h1},
        '{1'b0, `REG_STATUS, 32'h0, 32'h4000},
        '{1'b1, `REG_ORDER, 32'hffffffff, 32'h1fffff},
        '{1'b1, `REG_CONFIG, 32'hffffffff, 32'h0},
        '{1'b1, 4'h2, 32'hffffffff, 32'h0},
        '{1'b1, `REG_CTRL, 32'h7, 32'h7},
        '{1'b1, `REG_CTRL, 32'h1, 32'h1}};

    // ==========================================================
    // Clock, partner and designs
    always #12.5 clk = ~clk;
    clock_manager_model i_mgr (.run(run), .lock(lock_in),
        .fb_clk(fb_clk_in));
    safe_clock_startup_sequencer i_dut (.clk(clk), .rstn(rstn),
        .lock_in(lock_in), .fb_clk_in(fb_clk_in), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_en(gate_en),
        .ref_sel_out(ref_sel_out), .config_legal(config_legal));
    safe_clock_startup_sequencer #(.SS_EN(1'b1)) i_ss (.clk(clk),
        .rstn(rstn), .lock_in(lock_in), .fb_clk_in(fb_clk_in), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(), .gate_en(),
        .ref_sel_out(ss_ref), .config_legal(ss_legal));
    safe_clock_startup_sequencer #(.SS_EN(1'b1), .DPS_EN(1'b1)) i_bad (
        .clk(clk), .rstn(rstn), .lock_in(lock_in), .fb_clk_in(fb_clk_in),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
        .gate_en(), .ref_sel_out(), .config_legal(bad_legal));
    safe_clock_startup_sequencer #(.DYNRECFG_EN(1'b1), .MULT_FRAC(3'h1))
        i_frac (.clk(clk), .rstn(rstn), .lock_in(lock_in),
        .fb_clk_in(fb_clk_in), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(), .gate_en(), .ref_sel_out(),
        .config_legal(frac_legal));
    safe_clock_startup_sequencer #(.MINJIT_EN(1'b1), .MAXFILT_EN(1'b1))
        i_jit (.clk(clk), .rstn(rstn), .lock_in(lock_in),
        .fb_clk_in(fb_clk_in), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(), .gate_en(), .ref_sel_out(),
        .config_legal(jit_legal));

    // ==========================================================
    // Compare, bus and wait tasks
    task automatic results;
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
            mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word(rdata, e);
    endtask
    task automatic wait_gate(input logic [6:0] e, input int max);
        int i;
        for (i = 0; i < max; i++) begin
            @(posedge clk);
            #1;
            if (gate_en === e) break;
        end
        chk_word({25'h0, gate_en}, {25'h0, e});
        if (i == max) results();
    endtask
    task automatic hold_gate(input logic [6:0] e, input int n);
        repeat (n) @(posedge clk);
        #1;
        chk_word({25'h0, gate_en}, {25'h0, e});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k].w) wr_reg(rows[k].a, rows[k].d);
            rd_reg(rows[k].a, rows[k].e);
        end
        $display("register rows done");
        chk_flag(config_legal, 1'b1);
        chk_flag(ss_legal, 1'b1);
        chk_flag(bad_legal, 1'b0);
        chk_flag(frac_legal, 1'b0);
        chk_flag(jit_legal, 1'b0);
        wr_reg(`REG_CTRL, 32'h5);
        repeat (2) @(posedge clk);
        #1;
        chk_flag(ref_sel_out, 1'b1);
        chk_flag(ss_ref, 1'b0);
        wr_reg(`REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk_flag(ref_sel_out, 1'b0);
        $display("reference select done");
        run <= 1'b1;
        for (int i = 0; i < 100 && lock_in !== 1'b1; i++) @(posedge clk);
        chk_flag(lock_in, 1'b1);
        if (lock_in !== 1'b1) results();
        hold_gate(7'h00, 32);
        wait_gate(7'h7f, 5);
        run <= 1'b0;
        wait_gate(7'h00, 4);
        $display("safe startup done");
        wr_reg(`REG_CTRL, 32'h3);
        wr_reg(`REG_ORDER, 32'h8a042);
        run <= 1'b1;
        wait_gate(7'h0a, 120);
        hold_gate(7'h0a, 240);
        wait_gate(7'h2e, 40);
        run <= 1'b0;
        wait_gate(7'h00, 4);
        run <= 1'b1;
        wait_gate(7'h0a, 120);
        hold_gate(7'h0a, 240);
        wait_gate(7'h2e, 40);
        hold_gate(7'h2e, 230);
        wait_gate(7'h7f, 40);
        $display("sequencing done");
        rd_reg(`REG_STATUS, 32'h557f);
        @(posedge clk);
        rstn <= 1'b0;
        hold_gate(7'h00, 2);
        @(posedge clk);
        rstn <= 1'b1;
        rd_reg(`REG_CTRL, 32'h1);
        wr_reg(`REG_CTRL, 32'h0);
        wait_gate(7'h7f, 3);
        $display("reset done");
        results();
    end
endmodule
